// >>> logic/dfnc_pkg.sv
// Constants, field layouts and carrier types of the damping and adaptive notch control block.
// Assumes a 20 MHz APB clock and one 32-bit aligned word per register.
package dfnc_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_DAMP_BASE = 8'h04;
    localparam logic [7:0] OFF_DAMP_STEP = 8'h08;
    localparam logic [7:0] OFF_SET_DELTA = 8'h04;
    localparam logic [7:0] OFF_NOTCH3 = 8'h24;
    localparam logic [7:0] OFF_NOTCH4 = 8'h28;
    localparam logic [7:0] OFF_STATUS = 8'h2c;
    localparam logic [7:0] OFF_SAVED = 8'h30;
    localparam logic [7:0] OFF_MEAS = 8'h34;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_SW_LSB = 4;
    localparam int CTRL_ADS_LSB = 8;
    localparam int ST_EN_LSB = 0;
    localparam int ST_OK_LSB = 4;
    localparam int ST_NOTCH_EN_LSB = 8;
    localparam int ST_STATE_LSB = 12;
    localparam int ST_POS_BIT = 16;
    localparam int ST_TORQUE_BIT = 17;

    // ****************************************
    // Values after reset and limits
    // ****************************************
    localparam logic [15:0] NOTCH_OFF = 16'h1388;
    localparam logic [15:0] DAMP_FREQ_RST = 16'h0000;
    localparam logic [15:0] DAMP_SET_RST = 16'h0000;
    localparam logic [16:0] DAMP_SUM_MIN = 17'h00064;
    localparam logic [16:0] DAMP_SUM_MAX = 17'h007d0;

    // ****************************************
    // Mode encodings
    // ****************************************
    localparam logic [1:0] SW_FIXED = 2'h0;
    localparam logic [1:0] SW_ONE_INPUT = 2'h1;
    localparam logic [1:0] SW_TWO_INPUTS = 2'h2;
    localparam logic [1:0] SW_DIRECTION = 2'h3;
    localparam logic [2:0] ADS_OFF = 3'h0;
    localparam logic [2:0] ADS_ONE = 3'h1;
    localparam logic [2:0] ADS_TWO = 3'h2;
    localparam logic [2:0] ADS_MEASURE = 3'h3;
    localparam logic [2:0] ADS_CLEAR = 3'h4;
    localparam logic [3:0] CM_POSITION = 4'h0;
    localparam logic [3:0] CM_SPEED = 4'h1;
    localparam logic [3:0] CM_TORQUE = 4'h2;
    localparam logic [3:0] CM_POS_SPEED = 4'h3;
    localparam logic [3:0] CM_POS_TORQUE = 4'h4;
    localparam logic [3:0] CM_SPEED_TORQUE = 4'h5;
    localparam logic [3:0] CM_FULL_CLOSED = 4'h6;

    // ****************************************
    // Timing
    // ****************************************
    localparam longint unsigned CLK_HZ = 20000000;
    localparam longint unsigned SAVE_PERIOD_MIN = 30;
    localparam longint unsigned SAVE_PERIOD_CYCLES = SAVE_PERIOD_MIN * 60 * CLK_HZ;
    localparam int SAVE_CNT_W = 36;

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic [2:0] adaptive_notch_select;
        logic [1:0] damping_filter_switch_mode;
        logic [3:0] control_mode_select;
    } dfnc_ctrl_t;

    typedef struct packed {
        logic [15:0] notch_four_frequency;
        logic [15:0] notch_three_frequency;
    } dfnc_notch_t;

    typedef struct packed {
        logic valid;
        logic slot;
        logic [15:0] freq;
    } dfnc_est_t;

    typedef enum logic [3:0] {
        AN_OFF = 4'h1,
        AN_TRACK = 4'h2,
        AN_MEAS = 4'h4,
        AN_CLEAR = 4'h8
    } dfnc_an_state_t;

endpackage

// >>> logic/dfnc_damping_notch_ctrl.sv
// Damping filter selection, parameter store and adaptive notch management behind an APB slave.
// Assumes select inputs come from pins, estimator results and command direction from pclk logic.
//
// What this block does
// - Damping frequencies are held in 0.1 Hz units
// - Disabled filter also ignores its setting value
// - Selection 0 keeps filters one and two
// - Selection 1: input a picks one/three or two/four
// - Selection 2: both inputs decode one of four
// - Selection 3: direction picks one/three or two/four
// - Zero damping frequency means function unused
// - Damping only under position command control
// - Estimator result from speed vibration sets notch
// - Adapted frequency goes to notch three or four
// - Adaptive select 0 off, 1 one, 2 two
// - Adaptive select 3 enters frequency measurement mode
// - Adaptive select 4 clears and disables notches
// - Adaptive select 0 resets inertia and adaptation
// - Notch frequency 5000 disables that notch
// - Save notches every 30 minutes, restore at power-up
// - Torque control suspends adaptation, holds frequency
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module dfnc_damping_notch_ctrl #(
    parameter longint unsigned SAVE_CYCLES = dfnc_pkg::SAVE_PERIOD_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic damping_select_input_a,
    input wire logic damping_select_input_b,
    input wire logic cmd_reverse,
    input wire logic second_mode_active,
    input wire dfnc_pkg::dfnc_est_t est,
    input wire logic nv_restore_valid,
    input wire dfnc_pkg::dfnc_notch_t nv_restore,
    output logic [3:0] damp_enable,
    output logic [3:0][15:0] damp_freq_eff,
    output logic [3:0][15:0] damp_setting_eff,
    output dfnc_pkg::dfnc_notch_t notch_freq,
    output logic [1:0] notch_enable,
    output logic [1:0] adapt_count,
    output logic measure_mode,
    output logic estimator_reset,
    output logic nv_save_req,
    output dfnc_pkg::dfnc_notch_t nv_save_data
);
    import dfnc_pkg::*;

    // ****************************************
    // State
    // ****************************************
    dfnc_ctrl_t ctrl_r, ctrl_nxt;
    logic [15:0] dfreq_r [4];
    logic [15:0] dfreq_nxt [4];
    logic [15:0] dset_r [4];
    logic [15:0] dset_nxt [4];
    dfnc_notch_t notch_r, notch_nxt;
    dfnc_notch_t saved_r, saved_nxt;
    logic [15:0] meas_r, meas_nxt;
    dfnc_an_state_t an_r, an_nxt;
    logic [SAVE_CNT_W-1:0] save_cnt_r, save_cnt_nxt;
    logic save_req_r, save_req_nxt;
    logic est_rst_r, est_rst_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic [2:0] sync_a_r, sync_a_nxt, sync_b_r, sync_b_nxt;
    logic sel_a_r, sel_a_nxt, sel_b_r, sel_b_nxt;
    logic [3:0] den_r, den_nxt;
    logic [3:0][15:0] dfe_r, dfe_nxt, dse_r, dse_nxt;

    // ****************************************
    // Decode helpers
    // ****************************************
    logic wr_en;
    logic hit;
    logic [31:0] rd_data;
    logic pos_active;
    logic torque_active;
    logic [3:0] sel_mask;
    logic [3:0] range_ok;
    logic [1:0] notch_on;
    logic save_last;
    logic [16:0] sum [4];
    logic [16:0] lim [4];

    assign wr_en = psel && penable && pwrite && hit;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign save_last = (save_cnt_r == SAVE_CNT_W'(SAVE_CYCLES - 1));

    always_comb begin
        hit = (paddr[1:0] == 2'h0) && (paddr <= OFF_MEAS);
        rd_data = 32'h0000_0000;
        case (paddr)
            OFF_CTRL: begin
                rd_data[CTRL_MODE_LSB +: 4] = ctrl_r.control_mode_select;
                rd_data[CTRL_SW_LSB +: 2] = ctrl_r.damping_filter_switch_mode;
                rd_data[CTRL_ADS_LSB +: 3] = ctrl_r.adaptive_notch_select;
            end
            OFF_NOTCH3: rd_data = {16'h0000, notch_r.notch_three_frequency};
            OFF_NOTCH4: rd_data = {16'h0000, notch_r.notch_four_frequency};
            OFF_SAVED: rd_data = saved_r;
            OFF_MEAS: rd_data = {16'h0000, meas_r};
            OFF_STATUS: begin
                rd_data[ST_EN_LSB +: 4] = den_r;
                rd_data[ST_OK_LSB +: 4] = range_ok;
                rd_data[ST_NOTCH_EN_LSB +: 2] = notch_on;
                rd_data[ST_STATE_LSB +: 4] = an_r;
                rd_data[ST_POS_BIT] = pos_active;
                rd_data[ST_TORQUE_BIT] = torque_active;
            end
            default: begin
                for (int i = 0; i < 4; i++) begin
                    if (paddr == OFF_DAMP_BASE + 8'(i) * OFF_DAMP_STEP) begin
                        rd_data = {16'h0000, dfreq_r[i]};
                    end
                    if (paddr == OFF_DAMP_BASE + 8'(i) * OFF_DAMP_STEP + OFF_SET_DELTA) begin
                        rd_data = {16'h0000, dset_r[i]};
                    end
                end
            end
        endcase
    end

    // ****************************************
    // Control mode and filter selection
    // ****************************************
    always_comb begin
        case (ctrl_r.control_mode_select)
            CM_POSITION, CM_FULL_CLOSED: pos_active = 1'b1;
            CM_POS_SPEED, CM_POS_TORQUE: pos_active = !second_mode_active;
            default: pos_active = 1'b0;
        endcase
        case (ctrl_r.control_mode_select)
            CM_TORQUE: torque_active = 1'b1;
            CM_POS_TORQUE, CM_SPEED_TORQUE: torque_active = second_mode_active;
            default: torque_active = 1'b0;
        endcase
        case (ctrl_r.damping_filter_switch_mode)
            SW_FIXED: sel_mask = 4'b0011;
            SW_ONE_INPUT: sel_mask = sel_a_r ? 4'b1010 : 4'b0101;
            SW_TWO_INPUTS: sel_mask = 4'b0001 << {sel_b_r, sel_a_r};
            SW_DIRECTION: sel_mask = cmd_reverse ? 4'b1010 : 4'b0101;
            default: sel_mask = 4'b0000;
        endcase
        for (int i = 0; i < 4; i++) begin
            sum[i] = {1'b0, dfreq_r[i]} + {1'b0, dset_r[i]};
            lim[i] = {dfreq_r[i], 1'b0};
            if (lim[i] > DAMP_SUM_MAX) begin
                lim[i] = DAMP_SUM_MAX;
            end
            range_ok[i] = (sum[i] >= DAMP_SUM_MIN) && (sum[i] <= lim[i]);
        end
        notch_on[0] = notch_r.notch_three_frequency < NOTCH_OFF;
        notch_on[1] = notch_r.notch_four_frequency < NOTCH_OFF;
    end

    // ****************************************
    // Next values
    // ****************************************
    always_comb begin
        ctrl_nxt = ctrl_r;
        notch_nxt = notch_r;
        saved_nxt = saved_r;
        meas_nxt = meas_r;
        an_nxt = an_r;
        save_req_nxt = 1'b0;
        est_rst_nxt = 1'b0;
        save_cnt_nxt = save_last ? '0 : save_cnt_r + 1'b1;
        prdata_nxt = (psel && !penable) ? rd_data : prdata_r;
        sync_a_nxt = {sync_a_r[1:0], damping_select_input_a};
        sync_b_nxt = {sync_b_r[1:0], damping_select_input_b};
        sel_a_nxt = (sync_a_r[1] == sync_a_r[2]) ? sync_a_r[2] : sel_a_r;
        sel_b_nxt = (sync_b_r[1] == sync_b_r[2]) ? sync_b_r[2] : sel_b_r;
        for (int i = 0; i < 4; i++) begin
            dfreq_nxt[i] = dfreq_r[i];
            dset_nxt[i] = dset_r[i];
            if (wr_en && paddr == OFF_DAMP_BASE + 8'(i) * OFF_DAMP_STEP) begin
                dfreq_nxt[i] = pwdata[15:0];
            end
            if (wr_en && paddr == OFF_DAMP_BASE + 8'(i) * OFF_DAMP_STEP + OFF_SET_DELTA) begin
                dset_nxt[i] = pwdata[15:0];
            end
            den_nxt[i] = sel_mask[i] && pos_active && (|dfreq_r[i]);
            dfe_nxt[i] = den_nxt[i] ? dfreq_r[i] : 16'h0000;
            dse_nxt[i] = den_nxt[i] ? dset_r[i] : 16'h0000;
        end
        if (wr_en && paddr == OFF_CTRL) begin
            ctrl_nxt.control_mode_select = pwdata[CTRL_MODE_LSB +: 4];
            ctrl_nxt.damping_filter_switch_mode = pwdata[CTRL_SW_LSB +: 2];
            ctrl_nxt.adaptive_notch_select = pwdata[CTRL_ADS_LSB +: 3];
        end
        // Power-up restore has lowest priority, software next, hardware last
        if (nv_restore_valid) begin
            notch_nxt = nv_restore;
        end
        if (wr_en && paddr == OFF_NOTCH3) begin
            notch_nxt.notch_three_frequency = pwdata[15:0];
        end
        if (wr_en && paddr == OFF_NOTCH4) begin
            notch_nxt.notch_four_frequency = pwdata[15:0];
        end
        // Adaptive operating state follows the selection value
        case (ctrl_r.adaptive_notch_select)
            ADS_ONE, ADS_TWO: an_nxt = AN_TRACK;
            ADS_MEASURE: an_nxt = AN_MEAS;
            ADS_CLEAR: an_nxt = AN_CLEAR;
            default: an_nxt = AN_OFF;
        endcase
        if (an_nxt == AN_OFF && an_r != AN_OFF) begin
            est_rst_nxt = 1'b1;
        end
        case (an_r)
            AN_TRACK: begin
                if (est.valid && !torque_active) begin
                    if (!est.slot) begin
                        notch_nxt.notch_three_frequency = est.freq;
                    end else if (ctrl_r.adaptive_notch_select == ADS_TWO) begin
                        notch_nxt.notch_four_frequency = est.freq;
                    end
                end
            end
            AN_MEAS: begin
                if (est.valid && !torque_active) begin
                    meas_nxt = est.freq;
                end
            end
            AN_CLEAR: begin
                notch_nxt.notch_three_frequency = NOTCH_OFF;
                notch_nxt.notch_four_frequency = NOTCH_OFF;
                meas_nxt = 16'h0000;
            end
            AN_OFF: begin
                meas_nxt = meas_r;
            end
            default: an_nxt = AN_OFF;
        endcase
        if (save_last) begin
            save_req_nxt = 1'b1;
            saved_nxt = notch_r;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= '0;
            for (int i = 0; i < 4; i++) begin
                dfreq_r[i] <= DAMP_FREQ_RST;
                dset_r[i] <= DAMP_SET_RST;
            end
            notch_r <= {NOTCH_OFF, NOTCH_OFF};
            saved_r <= {NOTCH_OFF, NOTCH_OFF};
            meas_r <= 16'h0000;
            an_r <= AN_OFF;
            save_cnt_r <= '0;
            save_req_r <= 1'b0;
            est_rst_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            sync_a_r <= 3'h0;
            sync_b_r <= 3'h0;
            sel_a_r <= 1'b0;
            sel_b_r <= 1'b0;
            den_r <= 4'h0;
            dfe_r <= '0;
            dse_r <= '0;
        end else begin
            ctrl_r <= ctrl_nxt;
            for (int i = 0; i < 4; i++) begin
                dfreq_r[i] <= dfreq_nxt[i];
                dset_r[i] <= dset_nxt[i];
            end
            notch_r <= notch_nxt;
            saved_r <= saved_nxt;
            meas_r <= meas_nxt;
            an_r <= an_nxt;
            save_cnt_r <= save_cnt_nxt;
            save_req_r <= save_req_nxt;
            est_rst_r <= est_rst_nxt;
            prdata_r <= prdata_nxt;
            sync_a_r <= sync_a_nxt;
            sync_b_r <= sync_b_nxt;
            sel_a_r <= sel_a_nxt;
            sel_b_r <= sel_b_nxt;
            den_r <= den_nxt;
            dfe_r <= dfe_nxt;
            dse_r <= dse_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign prdata = prdata_r;
    assign damp_enable = den_r;
    assign damp_freq_eff = dfe_r;
    assign damp_setting_eff = dse_r;
    assign notch_freq = notch_r;
    assign notch_enable = notch_on;
    assign adapt_count = (an_r == AN_TRACK && !torque_active) ? ctrl_r.adaptive_notch_select[1:0]
                                                              : 2'h0;
    assign measure_mode = (an_r == AN_MEAS);
    assign estimator_reset = est_rst_r;
    assign nv_save_req = save_req_r;
    assign nv_save_data = saved_r;

endmodule

`default_nettype wire

// >>> test/dfnc_ctrl_assertions.sv
// Concurrent checks of the damping and adaptive notch control block.
// Assumes it is bound into the block and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module dfnc_ctrl_assertions #(
    parameter longint unsigned SAVE_CYCLES = 100
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] damp_enable,
    input wire logic [3:0][15:0] damp_setting_eff,
    input wire dfnc_pkg::dfnc_notch_t notch_freq,
    input wire logic [1:0] notch_enable,
    input wire logic [1:0] adapt_count,
    input wire logic measure_mode,
    input wire logic estimator_reset,
    input wire logic nv_save_req
);
    import dfnc_pkg::*;
    // ****************************************
    // Tracked control word and properties
    // ****************************************
    logic [2:0] ads_r;
    logic [3:0] mode_r;
    logic seen_r;
    longint unsigned cnt_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ads_r <= ADS_OFF;
            mode_r <= CM_POSITION;
            seen_r <= 1'b0;
            cnt_r <= 64'h0;
        end else begin
            if (psel && penable && pwrite && paddr == OFF_CTRL) begin
                ads_r <= pwdata[10:8];
                mode_r <= pwdata[3:0];
            end
            seen_r <= seen_r | nv_save_req;
            cnt_r <= nv_save_req ? 64'h1 : cnt_r + 64'h1;
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence held_s(logic [2:0] s);
        (ads_r == s && mode_r == CM_POSITION) [*4];
    endsequence
    notch_en_a: assert property (
        notch_enable == {notch_freq.notch_four_frequency < NOTCH_OFF,
        notch_freq.notch_three_frequency < NOTCH_OFF}) else $error("notch enable wrong");
    set_ignored_a: assert property (
        (damp_enable[0] || damp_setting_eff[0] == 16'h0) &&
        (damp_enable[1] || damp_setting_eff[1] == 16'h0) &&
        (damp_enable[2] || damp_setting_eff[2] == 16'h0) &&
        (damp_enable[3] || damp_setting_eff[3] == 16'h0)) else $error("setting not ignored");
    est_reset_a: assert property (
        estimator_reset |-> (ads_r == ADS_OFF || ads_r > ADS_CLEAR) ##1 !estimator_reset)
        else $error("reset pulse wrong");
    save_period_a: assert property (
        nv_save_req |-> (seen_r ? cnt_r == SAVE_CYCLES : cnt_r >= SAVE_CYCLES))
        else $error("save period wrong");
    save_bound_a: assert property (
        cnt_r <= SAVE_CYCLES + 64'h1) else $error("save pulse missing");
    clear_hold_a: assert property (
        held_s(ADS_CLEAR) |-> notch_freq == {NOTCH_OFF, NOTCH_OFF} && notch_enable == 2'h0)
        else $error("clear not held");
    measure_on_a: assert property (
        held_s(ADS_MEASURE) |-> measure_mode) else $error("measure mode missing");
    adapt_count_a: assert property (
        (held_s(ADS_ONE) |-> adapt_count == 2'h1) and (held_s(ADS_TWO) |-> adapt_count == 2'h2))
        else $error("adapt count wrong");
endmodule
bind dfnc_damping_notch_ctrl dfnc_ctrl_assertions #(.SAVE_CYCLES(SAVE_CYCLES)) chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .damp_enable(damp_enable),
    .damp_setting_eff(damp_setting_eff), .notch_freq(notch_freq), .notch_enable(notch_enable),
    .adapt_count(adapt_count), .measure_mode(measure_mode),
    .estimator_reset(estimator_reset), .nv_save_req(nv_save_req));
`default_nettype wire

// >>> test/dfnc_host_model.sv
// Host side model: select pins, direction, mode flag, estimator results, stored notches.
// Assumes its tasks are called from the bench; it changes pins just after rising edges.
`timescale 1ns/1ps
`default_nettype none
module dfnc_host_model (
    input wire logic pclk,
    output logic sel_a,
    output logic sel_b,
    output logic cmd_rev,
    output logic second,
    output dfnc_pkg::dfnc_est_t est,
    output logic nv_v,
    output dfnc_pkg::dfnc_notch_t nv_d
);
    import dfnc_pkg::*;
    // ****************************************
    // Pin drivers
    // ****************************************
    initial begin
        sel_a = 1'b0;
        sel_b = 1'b0;
        cmd_rev = 1'b0;
        second = 1'b0;
        est = '0;
        nv_v = 1'b0;
        nv_d = '1;
    end
    task automatic pins(input logic a, input logic b, input logic r, input logic s);
        @(posedge pclk);
        sel_a <= a;
        sel_b <= b;
        cmd_rev <= r;
        second <= s;
    endtask
    task automatic est_pulse(input logic slot, input logic [15:0] f);
        @(posedge pclk);
        est <= '{valid: 1'b1, slot: slot, freq: f};
        @(posedge pclk);
        est <= '{valid: 1'b0, slot: ~slot, freq: ~f};
    endtask
    task automatic restore(input dfnc_notch_t d);
        @(posedge pclk);
        nv_v <= 1'b1;
        nv_d <= d;
        @(posedge pclk);
        nv_v <= 1'b0;
        nv_d <= ~d;
    endtask
endmodule
`default_nettype wire

// >>> test/test_damping_and_adaptive_notch_ctrl.sv
// Self-checking bench of the damping and adaptive notch control block.
// Assumes the host model drives pins; APB is driven here.
`timescale 1ns/1ps
`default_nettype none
module test_damping_and_adaptive_notch_ctrl;
    import dfnc_pkg::*;
    // ****************************************
    // Signals, tasks and tests
    // ****************************************
    localparam longint unsigned SAVE_N = 100;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, sel_a, sel_b, rev, sec, nv_v, mm, erst, nsr, p;
    dfnc_est_t est;
    dfnc_notch_t nv_d, nf, nsd;
    logic [3:0] den, e, ok;
    logic [3:0][15:0] feff, seff;
    logic [1:0] nen, acnt;
    int fail_count = 0;
    int check_count = 0;
    int fq[4];
    int st[4];
    int n3 = 5000;
    int n4 = 5000;
    int f;
    always #25 pclk = ~pclk;
    dfnc_damping_notch_ctrl #(.SAVE_CYCLES(SAVE_N)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .damping_select_input_a(sel_a), .damping_select_input_b(sel_b), .cmd_reverse(rev),
        .second_mode_active(sec), .est(est), .nv_restore_valid(nv_v), .nv_restore(nv_d),
        .damp_enable(den), .damp_freq_eff(feff), .damp_setting_eff(seff),
        .notch_freq(nf), .notch_enable(nen), .adapt_count(acnt), .measure_mode(mm),
        .estimator_reset(erst), .nv_save_req(nsr), .nv_save_data(nsd));
    dfnc_host_model host_u (.pclk(pclk), .sel_a(sel_a), .sel_b(sel_b), .cmd_rev(rev),
        .second(sec), .est(est), .nv_v(nv_v), .nv_d(nv_d));
    task automatic chk(input logic [31:0] x, input logic [31:0] a);
        check_count++;
        if (a !== x) begin
            $display("[ERR] t=%0t exp=%h got=%h", $time, x, a);
            fail_count++;
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic ads(input logic [3:0] m, input logic [2:0] a);
        apb(1'b1, OFF_CTRL, 32'(m) | (32'(a) << CTRL_ADS_LSB));
        repeat (4) @(posedge pclk);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge pclk);
        fail_count++;
        final_report();
    end
    initial begin
        void'($urandom(16529));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({NOTCH_OFF, NOTCH_OFF}, nsd);
        apb(1'b0, OFF_NOTCH3, 32'h0);
        chk(32'h1388, rd);
        apb(1'b0, 8'h38, 32'h0);
        chk(32'h1, {31'h0, err});
        chk(32'h0, rd);
        $display("test reset done");
        fq[0] = 100;
        for (int i = 0; i < 4; i++) begin
            if (i > 0) fq[i] = 10 + $urandom_range(1989);
            st[i] = (i == 3) ? 2100 - fq[i] : $urandom_range(150);
            ok[i] = fq[i] + st[i] >= 100 && fq[i] + st[i] <= (fq[i] < 1000 ? 2 * fq[i] : 2000);
            apb(1'b1, OFF_DAMP_BASE + 8'(8 * i), 32'(fq[i]));
            apb(1'b1, OFF_DAMP_STEP + 8'(8 * i), 32'(st[i]));
            apb(1'b0, OFF_DAMP_BASE + 8'(8 * i), 32'h0);
            chk(32'(fq[i]), rd);
        end
        apb(1'b0, OFF_STATUS, 32'h0);
        chk(32'(ok), (rd >> ST_OK_LSB) & 32'hf);
        $display("test parameters done");
        for (int sw = 0; sw < 4; sw++) begin
            apb(1'b1, OFF_CTRL, 32'(sw << CTRL_SW_LSB));
            for (int k = 0; k < 8; k++) begin
                host_u.pins(k[0], k[1], k[2], 1'b0);
                repeat (6) @(posedge pclk);
                e = sw == 0 ? 4'h3 : sw == 2 ? 4'h1 << k[1:0] :
                    (sw == 1 ? k[0] : k[2]) ? 4'ha : 4'h5;
                chk(32'(e), 32'(den));
                for (int i = 0; i < 4; i++) begin
                    chk(e[i] ? 32'(st[i]) : 32'h0, 32'(seff[i]));
                    chk(e[i] ? 32'(fq[i]) : 32'h0, 32'(feff[i]));
                end
            end
        end
        for (int m = 0; m < 14; m++) begin
            apb(1'b1, OFF_CTRL, 32'(m >> 1));
            host_u.pins(1'b0, 1'b0, 1'b0, m[0]);
            repeat (6) @(posedge pclk);
            p = m < 2 || m > 11 || (m > 5 && m < 10 && !m[0]);
            chk(p ? 32'h3 : 32'h0, 32'(den));
        end
        apb(1'b1, OFF_DAMP_BASE, 32'h0);
        repeat (2) @(posedge pclk);
        chk(32'h2, 32'(den));
        chk(32'h0, 32'(seff[0]));
        $display("test selection done");
        host_u.pins(1'b0, 1'b0, 1'b0, 1'b0);
        ads(CM_POSITION, ADS_TWO);
        chk(32'h2, 32'(acnt));
        apb(1'b0, OFF_CTRL, 32'h0);
        chk(32'h200, rd);
        for (int s = 0; s < 3; s++) begin
            f = s == 2 ? 5000 : 300 + $urandom_range(4000);
            host_u.est_pulse(s[0], 16'(f));
            if (s == 1) n4 = f; else n3 = f;
            @(posedge pclk);
            chk({16'(n4), 16'(n3)}, nf);
        end
        chk(32'h2, 32'(nen));
        f = 0;
        do begin
            @(posedge pclk);
            f++;
        end while (nsr !== 1'b1 && f < 300);
        chk(32'h1, 32'(nsr));
        chk({16'(n4), 16'(n3)}, nsd);
        ads(CM_POSITION, ADS_ONE);
        chk(32'h1, 32'(acnt));
        host_u.est_pulse(1'b1, 16'h04d2);
        @(posedge pclk);
        chk({16'(n4), 16'(n3)}, nf);
        host_u.pins(1'b0, 1'b0, 1'b0, 1'b1);
        ads(CM_SPEED_TORQUE, ADS_TWO);
        chk(32'h0, 32'(acnt));
        host_u.est_pulse(1'b0, 16'h0309);
        @(posedge pclk);
        chk({16'(n4), 16'(n3)}, nf);
        ads(CM_POSITION, ADS_TWO);
        chk(32'h2, 32'(acnt));
        chk({16'(n4), 16'(n3)}, nf);
        ads(CM_POSITION, ADS_MEASURE);
        chk(32'h1, 32'(mm));
        host_u.est_pulse(1'b0, 16'h0abc);
        apb(1'b0, OFF_MEAS, 32'h0);
        chk(32'h0abc, rd);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk(32'(AN_MEAS), (rd >> ST_STATE_LSB) & 32'hf);
        apb(1'b1, OFF_CTRL, 32'h0);
        f = 0;
        while (erst !== 1'b1 && f < 8) begin
            @(posedge pclk);
            f++;
        end
        chk(32'h1, 32'(erst));
        host_u.restore({16'h0258, 16'h02bc});
        @(posedge pclk);
        chk(32'h025802bc, nf);
        chk(32'h0, 32'(acnt));
        ads(CM_POSITION, ADS_CLEAR);
        chk({NOTCH_OFF, NOTCH_OFF}, nf);
        chk(32'h0, 32'(nen));
        $display("test adaptive done");
        final_report();
    end
endmodule
`default_nettype wire
